// file: bench/gsw_gain_switch_assertions.sv
`include "gsw_regs.vh"
`default_nettype none
// ==========================================================
// port checker for the gain switch
module gsw_sva #(
  parameter MS_CYCLES = 20
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // conditions and results
  input wire logic gain_change_in,
  input wire logic [15:0] command_freq,
  input wire logic [15:0] droop_pulses,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] model_loop_gain,
  input wire logic alt_set_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sel_r;
  logic [15:0] lvl_r;
  logic [3:0] tune_r;
  wire wr = psel && penable && pready && pwrite;
  wire wr_model = wr && paddr == `GSW_OFS_MODEL;
  wire man = tune_r == `GSW_TUNE_MANUAL;
  wire lvl_src = sel_r >= 8'h02 && sel_r <= 8'h04;
  wire pin_mode = man && sel_r == 8'h01;
  wire [15:0] qty = sel_r == 8'h02 ? command_freq : sel_r == 8'h03 ? droop_pulses : motor_speed;
  wire hit = qty >= lvl_r;
  // shadow of the control fields, committed on the same edge as inside the block
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sel_r <= 8'h01;
      lvl_r <= `GSW_RST_LEVEL;
      tune_r <= `GSW_RST_TUNING;
    end
    else if (wr)
    begin
      if (paddr == `GSW_OFS_SELECT) sel_r <= pwdata[7:0];
      if (paddr == `GSW_OFS_LEVEL) lvl_r <= pwdata[15:0];
      if (paddr == `GSW_OFS_TUNING) tune_r <= pwdata[3:0];
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // assertions
  chk_ready_setup: assert property (psel && !penable |=> pready) else $error("no answer");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
  chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0) else $error("bad error");
  chk_hole_err: assert property (psel && !penable && paddr == 12'h02c |=> pslverr) else $error("hole");
  chk_model_hold: assert property ($changed(model_loop_gain) |-> $past(wr_model) || $past(wr_model, 2))
    else $error("model gain moved");
  chk_pin_high: assert property ((pin_mode && gain_change_in) [*4] |=> alt_set_active) else $error("pin hi");
  chk_pin_low: assert property ((pin_mode && !gain_change_in) [*4] |=> !alt_set_active) else $error("pin lo");
  chk_level_pick: assert property (lvl_src && man |=> alt_set_active == $past(hit)) else $error("level");
  chk_tune_block: assert property (!man |=> !alt_set_active) else $error("tuning");
  chk_code_other: assert property (man && !lvl_src && sel_r != 8'h01 |=> !alt_set_active) else $error("code");
endmodule // gsw_sva

bind gsw_gain_switch gsw_sva #(.MS_CYCLES(MS_CYCLES)) chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .gain_change_in(gain_change_in), .command_freq(command_freq), .droop_pulses(droop_pulses),
  .motor_speed(motor_speed), .model_loop_gain(model_loop_gain), .alt_set_active(alt_set_active));
`default_nettype wire

// file: bench/gsw_host_model.sv
`default_nettype none
// ==========================================================
// host driving the gain change pin
module gsw_host_model (
  // request from the bench
  input wire logic pclk,
  input wire logic want,
  input wire logic [3:0] lag,
  // pin
  output logic gain_change_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt = 4'h0;
  // pin follows the request lag+1 cycles later, so slow hosts are covered too
  initial gain_change_in = 1'b0;
  always @(posedge pclk)
  begin
    if (want == gain_change_in) cnt <= 4'h0;
    else if (cnt >= lag) gain_change_in <= want;
    else cnt <= cnt + 4'h1;
  end
endmodule // gsw_host_model
`default_nettype wire

// file: bench/servo_gain_switching_tb_top.sv
`include "gsw_regs.vh"
`default_nettype none
// ==========================================================
// bench top
module servo_gain_switching_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MSC = 20;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic want = 1'b0;
  logic [3:0] lag = 4'h0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] cf = 16'h0;
  logic [15:0] dp = 16'h0;
  logic [15:0] ms = 16'h0;
  logic [31:0] rd;
  logic err;
  logic [15:0] lv;
  logic [15:0] q;
  logic [15:0] mdl;
  wire [31:0] prdata;
  wire pready, pslverr, pin, alt;
  wire [15:0] model, iner, pos, sg, ig, v1, v2;
  int bad_count = 0;
  int cmp_count = 0;
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin bad_count++; $display("FAIL %s exp %h got %h", n, e, s); end end
  gsw_gain_switch #(.MS_CYCLES(MSC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gain_change_in(pin), .command_freq(cf), .droop_pulses(dp), .motor_speed(ms), .model_loop_gain(model),
    .load_inertia_ratio(iner), .position_loop_gain(pos), .speed_loop_gain(sg), .speed_integral_comp(ig),
    .vib_supp_vibration_freq(v1), .vib_supp_resonance_freq(v2), .alt_set_active(alt));
  gsw_host_model host_u (.pclk(pclk), .want(want), .lag(lag), .gain_change_in(pin));
  initial forever #10 pclk = ~pclk;
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // one transfer; an idle cycle follows so no signal is driven twice in one step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 40)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 40)
      bad_count++; // a slave that never answers counts as a mismatch
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // quantity of code c gets v, the other two get noise
  task automatic setq(input int c, input logic [15:0] v);
    cf <= c == 2 ? v : 16'($urandom);
    dp <= c == 3 ? v : 16'($urandom);
    ms <= c == 4 ? v : 16'($urandom);
    tick(3);
  endtask
  function automatic logic hit(input logic [15:0] x, input logic [15:0] l);
    return x >= l;
  endfunction
  // outputs sit on their targets when the time constant is zero
  task automatic chkset(input logic a, input logic v);
    `CHK("alt", a, alt)
    `CHK("pos", a ? `GSW_RST_A_POS : `GSW_RST_N_POS, pos)
    `CHK("iner", a ? `GSW_RST_A_INER : `GSW_RST_N_INER, iner)
    `CHK("spd", a ? `GSW_RST_A_SPD : `GSW_RST_N_SPD, sg)
    `CHK("int", a ? `GSW_RST_A_INT : `GSW_RST_N_INT, ig)
    `CHK("vib_supp_vibration_freq", v ? `GSW_RST_A_VRF : `GSW_RST_N_VRF, v1)
    `CHK("vib_supp_resonance_freq", v ? `GSW_RST_A_VRF : `GSW_RST_N_VRF, v2)
    `CHK("model", mdl, model)
  endtask
  task automatic complete_run;
    if (bad_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog, well beyond the expected run of about 1400 cycles
  initial
  begin
    #(20 * 6000);
    bad_count++;
    complete_run();
  end
  // ==========================================================
  // main sequence
  initial
  begin
    void'($urandom(32'h2bfa2aa9));
    mdl = `GSW_RST_MODEL;
    tick(3);
    presetn <= 1'b1;
    tick(3);
    chkset(1'b0, 1'b0);
    apb(1'b0, `GSW_OFS_SELECT, 32'h0);
    `CHK("sel", 32'h1, rd)
    apb(1'b0, 12'h02c, 32'h0);
    `CHK("err", 1'b1, err)
    mdl = 16'($urandom);
    apb(1'b1, `GSW_OFS_MODEL, {16'h0, mdl});
    apb(1'b1, `GSW_OFS_TCONST, 32'h0);
    for (int k = 0; k < 2; k++)
    begin
      lag <= k ? 4'h9 : 4'h0;
      want <= 1'b1;
      tick(20);
      chkset(1'b1, 1'b1);
      want <= 1'b0;
      tick(20);
      chkset(1'b0, 1'b0);
    end
    for (int c = 2; c < 5; c++)
    begin
      lv = 16'($urandom_range(1, 65534));
      q = 16'($urandom);
      apb(1'b1, `GSW_OFS_SELECT, 32'(c));
      apb(1'b1, `GSW_OFS_LEVEL, {16'h0, lv});
      setq(c, lv);
      chkset(hit(lv, lv), 1'b0);
      setq(c, lv - 16'h1);
      chkset(hit(lv - 16'h1, lv), 1'b0);
      setq(c, q);
      chkset(hit(q, lv), 1'b0);
    end
    setq(4, 16'hffff);
    apb(1'b1, `GSW_OFS_TUNING, 32'($urandom_range(0, 2)));
    tick(3);
    chkset(1'b0, 1'b0);
    apb(1'b1, `GSW_OFS_TUNING, 32'h3);
    apb(1'b1, `GSW_OFS_SELECT, 32'h104);
    tick(3);
    chkset(1'b1, 1'b0);
    // status: pin low, alternate wanted, speed source
    apb(1'b0, `GSW_OFS_STATUS, 32'h0);
    `CHK("status", 32'h0000_0104, rd)
    apb(1'b1, `GSW_OFS_SELECT, 32'h014);
    tick(3);
    chkset(1'b0, 1'b0);
    apb(1'b1, `GSW_OFS_SELECT, 32'h4);
    setq(4, 16'h0);
    apb(1'b1, `GSW_OFS_TCONST, 32'h4);
    setq(4, 16'hffff);
    tick(MSC + 2);
    `CHK("lag", 1'b1, pos > `GSW_RST_A_POS && pos < `GSW_RST_N_POS)
    tick(MSC * 60);
    `CHK("settle", 1'b1, pos <= `GSW_RST_A_POS + 16'h1)
    // host keeps the inertia ratio equal in both sets when the load does not change
    apb(1'b1, `GSW_OFS_TCONST, 32'h0);
    apb(1'b1, `GSW_OFS_ALT0, {16'h0, `GSW_RST_N_INER});
    tick(3);
    `CHK("alt_hold", 1'b1, alt)
    `CHK("iner_eq", `GSW_RST_N_INER, iner)
    complete_run();
  end
endmodule // servo_gain_switching_tb_top
`default_nettype wire

// file: hdl/gsw_gain_switch.v
// Implementation choices: the register offsets and register access over APB.
`include "gsw_regs.vh"
`default_nettype none
module gsw_gain_switch #(
  parameter MS_CYCLES = `GSW_MS_CYCLES
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // conditions
  input wire gain_change_in,
  input wire [15:0] command_freq,
  input wire [15:0] droop_pulses,
  input wire [15:0] motor_speed,
  // active loop values
  output reg [15:0] model_loop_gain,
  output wire [15:0] load_inertia_ratio,
  output wire [15:0] position_loop_gain,
  output wire [15:0] speed_loop_gain,
  output wire [15:0] speed_integral_comp,
  output wire [15:0] vib_supp_vibration_freq,
  output wire [15:0] vib_supp_resonance_freq,
  output reg alt_set_active
);
  // ==========================================================
  // register storage
  reg [11:0] gain_change_select_r;
  reg [15:0] gain_change_level_r;
  reg [15:0] gain_change_time_constant_r;
  reg [3:0] tuning_mode_r;
  reg [15:0] model_r;
  reg [15:0] norm_r [0:5];
  reg [15:0] alt_r [0:5];
  reg [1:0] sync_r;
  reg [15:0] tick_cnt_r;
  reg ms_tick_r;
  reg [7:0] src_code;
  reg above_level;
  reg use_alt_nxt;
  reg [31:0] rd_data;
  reg rd_ok;
  wire [95:0] filt_out;
  integer i;

  // index of a register word inside a bank, or 7 when outside it
  function [2:0] bank_index;
    input [11:0] addr;
    input [11:0] base;
    reg [11:0] off;
    begin
      off = addr - base;
      if (off[1:0] == 2'b00 && off < 12'h018)
        bank_index = off[4:2];
      else
        bank_index = 3'h7;
    end
  endfunction

  wire wr_en = psel & penable & pready & pwrite;
  wire [2:0] norm_idx = bank_index(paddr, `GSW_OFS_NORM0);
  wire [2:0] alt_idx = bank_index(paddr, `GSW_OFS_ALT0);

  // ==========================================================
  // external input passes two flops because it comes off a pin
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_r <= 2'b00;
    else
      sync_r <= {sync_r[0], gain_change_in};
  end

  // millisecond tick for the lag filters
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b0;
    end
    else if (tick_cnt_r == MS_CYCLES[15:0] - 16'h0001)
    begin
      tick_cnt_r <= 16'h0000;
      ms_tick_r <= 1'b1;
    end
    else
    begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
      ms_tick_r <= 1'b0;
    end
  end

  // ==========================================================
  // condition decode
  always @*
  begin
    src_code = gain_change_select_r[`GSW_SEL_CODE_HI:`GSW_SEL_CODE_LO];
    above_level = 1'b0;
    use_alt_nxt = 1'b0;
    case (src_code)
      `GSW_SRC_INPUT: use_alt_nxt = sync_r[1];
      `GSW_SRC_CMDFREQ: above_level = command_freq >= gain_change_level_r;
      `GSW_SRC_DROOP: above_level = droop_pulses >= gain_change_level_r;
      `GSW_SRC_SPEED: above_level = motor_speed >= gain_change_level_r;
      default: use_alt_nxt = 1'b0;
    endcase
    if (src_code != `GSW_SRC_INPUT)
      use_alt_nxt = above_level;
    if (tuning_mode_r != `GSW_TUNE_MANUAL)
      use_alt_nxt = 1'b0; // auto tuning owns the gains
  end

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      alt_set_active <= 1'b0;
    else
      alt_set_active <= use_alt_nxt;
  end

  // ==========================================================
  // lag filters, one per switched value
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1)
    begin : g_filt
      // vibration frequencies stay normal unless the pin drives the change
      wire vrf_hold = (g >= `GSW_IDX_VIB_SUPP_VIBRATION_FREQ) && (src_code != `GSW_SRC_INPUT);
      wire [15:0] tgt = (alt_set_active && !vrf_hold) ? alt_r[g] : norm_r[g];
      gsw_lag_filter #(
        .W(16)
      ) u_filt (
        .pclk(pclk),
        .presetn(presetn),
        .ms_tick(ms_tick_r),
        .tconst_ms(gain_change_time_constant_r),
        .init_val(norm_r[g]),
        .target(tgt),
        .value(filt_out[g*16+15:g*16])
      );
    end
  endgenerate

  assign load_inertia_ratio = filt_out[16*`GSW_IDX_INERTIA+15:16*`GSW_IDX_INERTIA];
  assign position_loop_gain = filt_out[16*`GSW_IDX_POS+15:16*`GSW_IDX_POS];
  assign speed_loop_gain = filt_out[16*`GSW_IDX_SPEED+15:16*`GSW_IDX_SPEED];
  assign speed_integral_comp = filt_out[16*`GSW_IDX_INTEG+15:16*`GSW_IDX_INTEG];
  assign vib_supp_vibration_freq = filt_out[16*`GSW_IDX_VIB_SUPP_VIBRATION_FREQ+15:16*`GSW_IDX_VIB_SUPP_VIBRATION_FREQ];
  assign vib_supp_resonance_freq = filt_out[16*`GSW_IDX_VIB_SUPP_RESONANCE_FREQ+15:16*`GSW_IDX_VIB_SUPP_RESONANCE_FREQ];

  // model loop gain bypasses switching and filtering
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      model_loop_gain <= `GSW_RST_MODEL;
    else
      model_loop_gain <= model_r;
  end

  // ==========================================================
  // register writes, taken in the access cycle only
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gain_change_select_r <= `GSW_RST_SELECT;
      gain_change_level_r <= `GSW_RST_LEVEL;
      gain_change_time_constant_r <= `GSW_RST_TCONST;
      tuning_mode_r <= `GSW_RST_TUNING;
      model_r <= `GSW_RST_MODEL;
      norm_r[0] <= `GSW_RST_N_INER;
      norm_r[1] <= `GSW_RST_N_POS;
      norm_r[2] <= `GSW_RST_N_SPD;
      norm_r[3] <= `GSW_RST_N_INT;
      norm_r[4] <= `GSW_RST_N_VRF;
      norm_r[5] <= `GSW_RST_N_VRF;
      alt_r[0] <= `GSW_RST_A_INER;
      alt_r[1] <= `GSW_RST_A_POS;
      alt_r[2] <= `GSW_RST_A_SPD;
      alt_r[3] <= `GSW_RST_A_INT;
      alt_r[4] <= `GSW_RST_A_VRF;
      alt_r[5] <= `GSW_RST_A_VRF;
    end
    else if (wr_en)
    begin
      if (paddr == `GSW_OFS_SELECT)
        gain_change_select_r <= pwdata[11:0];
      if (paddr == `GSW_OFS_LEVEL)
        gain_change_level_r <= pwdata[15:0];
      if (paddr == `GSW_OFS_TCONST)
        gain_change_time_constant_r <= pwdata[15:0];
      if (paddr == `GSW_OFS_TUNING)
        tuning_mode_r <= pwdata[3:0];
      if (paddr == `GSW_OFS_MODEL)
        model_r <= pwdata[15:0];
      for (i = 0; i < 6; i = i + 1)
      begin
        if (norm_idx == i[2:0])
          norm_r[i] <= pwdata[15:0];
        if (alt_idx == i[2:0])
          alt_r[i] <= pwdata[15:0];
      end
    end
  end

  // ==========================================================
  // read mux; status word shows the live selection
  always @*
  begin
    rd_ok = 1'b1;
    rd_data = 32'h0000_0000;
    if (norm_idx != 3'h7)
      rd_data = {16'h0000, norm_r[norm_idx]};
    else if (alt_idx != 3'h7)
      rd_data = {16'h0000, alt_r[alt_idx]};
    else
      case (paddr)
        `GSW_OFS_SELECT: rd_data = {20'h00000, gain_change_select_r};
        `GSW_OFS_LEVEL: rd_data = {16'h0000, gain_change_level_r};
        `GSW_OFS_TCONST: rd_data = {16'h0000, gain_change_time_constant_r};
        `GSW_OFS_TUNING: rd_data = {28'h0000000, tuning_mode_r};
        `GSW_OFS_MODEL: rd_data = {16'h0000, model_r};
        `GSW_OFS_STATUS: rd_data = {22'h000000, sync_r[1], use_alt_nxt, src_code};
        default: rd_ok = 1'b0;
      endcase
  end

  // no wait state: answer prepared in setup, presented in the first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel && !penable)
    begin
      pready <= 1'b1;
      prdata <= pwrite ? 32'h0000_0000 : rd_data;
      pslverr <= !rd_ok; // unmapped address refused, write dropped
    end
    else
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end
endmodule // gsw_gain_switch
`default_nettype wire

// file: hdl/gsw_lag_filter.v
`default_nettype none
// ==========================================================
// first-order lag toward a target, stepped once per millisecond
module gsw_lag_filter #(
  parameter W = 16
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // control
  input wire ms_tick,
  input wire [15:0] tconst_ms,
  input wire [W-1:0] init_val,
  input wire [W-1:0] target,
  // result
  output wire [W-1:0] value
);
  // state keeps 16 fraction bits so small steps are not lost to truncation
  reg [W+15:0] state_r;
  wire signed [W+16:0] err;
  wire signed [W+16:0] step;
  reg init_done_r;

  assign err = $signed({1'b0, target, 16'h0000}) - $signed({1'b0, state_r});
  assign step = err / $signed({{(W+1){1'b0}}, tconst_ms});
  assign value = state_r[W+15:16];

  // each tick moves the state by err/tc, giving an exponential with tc ms time constant
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= {(W+16){1'b0}};
      init_done_r <= 1'b0;
    end
    else if (!init_done_r)
    begin
      state_r <= {init_val, 16'h0000};
      init_done_r <= 1'b1;
    end
    else if (tconst_ms == 16'h0000)
      state_r <= {target, 16'h0000}; // zero time constant switches at once
    else if (ms_tick)
      state_r <= state_r + step[W+15:0];
  end
endmodule // gsw_lag_filter
`default_nettype wire

// file: pkg/gsw_regs.vh
`ifndef GSW_REGS_VH
`define GSW_REGS_VH
// ==========================================================
// register byte offsets
`define GSW_OFS_SELECT   12'h000
`define GSW_OFS_LEVEL    12'h004
`define GSW_OFS_TCONST   12'h008
`define GSW_OFS_TUNING   12'h00c
`define GSW_OFS_NORM0    12'h010
`define GSW_OFS_MODEL    12'h028
`define GSW_OFS_ALT0     12'h030
`define GSW_OFS_STATUS   12'h048
// ==========================================================
// field positions and codes
`define GSW_SEL_CODE_HI  7
`define GSW_SEL_CODE_LO  0
`define GSW_SRC_NONE     8'h00
`define GSW_SRC_INPUT    8'h01
`define GSW_SRC_CMDFREQ  8'h02
`define GSW_SRC_DROOP    8'h03
`define GSW_SRC_SPEED    8'h04
`define GSW_TUNE_MANUAL  4'h3
`define GSW_IDX_INERTIA  0
`define GSW_IDX_POS      1
`define GSW_IDX_SPEED    2
`define GSW_IDX_INTEG    3
`define GSW_IDX_VIB_SUPP_VIBRATION_FREQ     4
`define GSW_IDX_VIB_SUPP_RESONANCE_FREQ     5
// ==========================================================
// reset values
`define GSW_RST_SELECT   12'h001
`define GSW_RST_LEVEL    16'h0032
`define GSW_RST_TCONST   16'h0064
`define GSW_RST_TUNING   4'h3
`define GSW_RST_MODEL    16'h0064
`define GSW_RST_N_INER   16'h0028
`define GSW_RST_N_POS    16'h0078
`define GSW_RST_N_SPD    16'h0bb8
`define GSW_RST_N_INT    16'h0014
`define GSW_RST_N_VRF    16'h0032
`define GSW_RST_A_INER   16'h0064
`define GSW_RST_A_POS    16'h0054
`define GSW_RST_A_SPD    16'h0fa0
`define GSW_RST_A_INT    16'h0032
`define GSW_RST_A_VRF    16'h003c
// ==========================================================
// timing
`define GSW_CLK_PERIOD_NS 20
`define GSW_MS_NS         1000000
`define GSW_MS_CYCLES     (`GSW_MS_NS / `GSW_CLK_PERIOD_NS)
`endif
